// >>> common/hotswap_pkg.sv
// Constants, types and timing figures for the differential bus hot-swap connect logic.
// ****************************************************************
// Overview of operation
// - While enable is low the card side stays isolated from both differential pairs.
// - With enable high and supplies stable, couple only after STOP or bus idle.
// - During power-on everything is disconnected with all pins released.
// - After supplies rise, a 1 ms timer runs before line sensing starts.
// - Lines count as terminated when minus below 0.9 and plus above 0.1 supply.
// - Connect on enable with idle plus lines, or card lines high and a STOP.
// - On disconnect status or power loss, separate and repeat the whole sequence.
// - Each pair node drives or receives, never both, switching automatically.
// - Plus more positive than minus is the released, high state.
// - Line state is taken only from the sign of plus minus minus.
// - A reversed pair pulls the matching card-side line low.
// - A STOP is data rising while clock stays high on the pairs.
// - Enable is active high and reads high when left undriven.
// ****************************************************************
package hotswap_pkg;

    localparam int  CLK_HZ          = 10_000_000;
    localparam real REF_DELAY_MS    = 1.0;
    localparam real TERM_DELAY_MS   = 10.0;
    localparam int  REF_CYCLES      = int'(REF_DELAY_MS * CLK_HZ / 1000.0);
    localparam int  TERM_CYCLES     = int'(TERM_DELAY_MS * CLK_HZ / 1000.0);
    localparam int  IDLE_CYCLES_DEF = 500;
    localparam int  CNT_W           = 17;

    // Comparator results from the analog front end: a sign per pair, a threshold per line.
    typedef struct packed {
        logic clk_plus_gt_minus;
        logic data_plus_gt_minus;
        logic clk_minus_below_hi;
        logic data_minus_below_hi;
        logic clk_plus_above_lo;
        logic data_plus_above_lo;
    } line_sense_t;

    // One open-drain pin: out value, enable low while driving.
    typedef struct packed {
        logic o;
        logic oe_n;
    } od_pin_t;

    typedef enum logic [5:0] {
        ST_POWER_UP = 6'h01,
        ST_REF_WAIT = 6'h02,
        ST_SENSE    = 6'h04,
        ST_TERM_WAIT= 6'h08,
        ST_ARMED    = 6'h10,
        ST_CONNECT  = 6'h20
    } seq_state_t;

endpackage

// >>> rtl/sync3.sv
// Three-flop input synchroniser with agreement filter.
`timescale 1ns/10ps
module sync3 (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic rst_val,
    input  wire logic d,
    output logic      q
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // A change is accepted only once the second and third stages agree.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_reg <= rst_val;
            s2_reg <= rst_val;
            s3_reg <= rst_val;
            q      <= rst_val;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                q <= s3_reg;
            end
        end
    end
endmodule

// >>> rtl/diff_bus_hotswap_connect.sv
// Hot-swap sequencer and direction logic of a two-channel differential bus buffer.
`timescale 1ns/10ps
module diff_bus_hotswap_connect #(
    parameter int REF_CNT  = hotswap_pkg::REF_CYCLES,
    parameter int TERM_CNT = hotswap_pkg::TERM_CYCLES,
    parameter int IDLE_CNT = hotswap_pkg::IDLE_CYCLES_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     supplies_ok,
    input  wire logic                     connect_en,
    input  wire hotswap_pkg::line_sense_t sense,
    input  wire logic                     card_scl_in,
    input  wire logic                     card_sda_in,
    output hotswap_pkg::od_pin_t          card_scl,
    output hotswap_pkg::od_pin_t          card_sda,
    output hotswap_pkg::od_pin_t          clk_diff_plus,
    output hotswap_pkg::od_pin_t          clk_diff_minus,
    output hotswap_pkg::od_pin_t          data_diff_plus,
    output hotswap_pkg::od_pin_t          data_diff_minus,
    output logic                          connected,
    output logic                          sensing_on
);
    import hotswap_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic pwr_s, en_s, ck_s, dt_s, scl_s, sda_s, term_s;
    logic term_raw;

    // Termination check uses only the threshold comparators.
    assign term_raw = sense.clk_minus_below_hi & sense.data_minus_below_hi
                    & sense.clk_plus_above_lo & sense.data_plus_above_lo;

    // Supplies count as absent out of reset, so the reference wait does not start before they are seen.
    sync3 u_pwr  (.clk(clk), .reset_n(reset_n), .rst_val(1'b0), .d(supplies_ok),
                  .q(pwr_s));
    // An undriven enable resolves high in the pad; the reset value matches.
    sync3 u_en   (.clk(clk), .reset_n(reset_n), .rst_val(1'b1), .d(connect_en), .q(en_s));
    sync3 u_ck   (.clk(clk), .reset_n(reset_n), .rst_val(1'b1),
                  .d(sense.clk_plus_gt_minus), .q(ck_s));
    sync3 u_dt   (.clk(clk), .reset_n(reset_n), .rst_val(1'b1),
                  .d(sense.data_plus_gt_minus), .q(dt_s));
    sync3 u_scl  (.clk(clk), .reset_n(reset_n), .rst_val(1'b1), .d(card_scl_in),
                  .q(scl_s));
    sync3 u_sda  (.clk(clk), .reset_n(reset_n), .rst_val(1'b1), .d(card_sda_in),
                  .q(sda_s));
    sync3 u_term (.clk(clk), .reset_n(reset_n), .rst_val(1'b0), .d(term_raw), .q(term_s));

    // Pair level is the sign of the difference alone; plus above minus is high.
    logic line_clk_hi;
    logic line_dat_hi;
    assign line_clk_hi = ck_s;
    assign line_dat_hi = dt_s;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [CNT_W-1:0] timer_reg;
    logic [CNT_W-1:0] idle_reg;
    logic dat_prev_reg;
    logic stop_seen_reg;
    logic timer_done;
    logic idle_done;
    logic stop_evt;

    assign timer_done = (state_reg == ST_REF_WAIT) ? (timer_reg >= CNT_W'(REF_CNT - 1))
                                                   : (timer_reg >= CNT_W'(TERM_CNT - 1));
    // Idle time is a module parameter.
    assign idle_done  = (idle_reg >= CNT_W'(IDLE_CNT));
    // Data rising while clock stays high.
    assign stop_evt   = line_clk_hi & line_dat_hi & ~dat_prev_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_POWER_UP:  if (pwr_s) state_next = ST_REF_WAIT;
            ST_REF_WAIT:  if (timer_done) state_next = ST_SENSE;
            ST_SENSE:     if (term_s) state_next = ST_TERM_WAIT;
            ST_TERM_WAIT: begin
                if (!term_s) state_next = ST_SENSE;
                else if (timer_done) state_next = ST_ARMED;
            end
            ST_ARMED: begin
                // Connect only on enable plus idle, or STOP with card lines high.
                if (en_s && (idle_done || (stop_seen_reg && scl_s && sda_s)))
                    state_next = ST_CONNECT;
            end
            ST_CONNECT: begin
                // Enable low or lost termination drops back for a full rerun.
                if (!en_s || !term_s) state_next = ST_POWER_UP;
            end
            default:      state_next = ST_POWER_UP;
        endcase
        // Power loss always restarts the sequence.
        if (!pwr_s) state_next = ST_POWER_UP;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= ST_POWER_UP;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || state_next != state_reg) begin
            timer_reg <= '0;
        end else if (!timer_done) begin
            timer_reg <= timer_reg + 1'b1;
        end
    end

    // Idle counter needs both plus lines high without break.
    always_ff @(posedge clk) begin
        if (!reset_n || state_reg != ST_ARMED || !(line_clk_hi && line_dat_hi)) begin
            idle_reg <= '0;
        end else if (!idle_done) begin
            idle_reg <= idle_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dat_prev_reg  <= 1'b1;
            stop_seen_reg <= 1'b0;
        end else begin
            dat_prev_reg <= line_dat_hi;
            if (state_reg != ST_ARMED || !line_clk_hi || !line_dat_hi) begin
                stop_seen_reg <= stop_evt;
            end else if (stop_evt) begin
                stop_seen_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Direction and pin drive
    // ****************************************************************
    // A side that is pulled low first owns the channel until it releases,
    // so the buffer's own drive never echoes back as a new source.
    // After an owner lets go, the side that was driven is ignored until its
    // synchronised level reads high again; otherwise the three-flop delay would
    // send the released low straight back across. A low held there by another
    // node in that time is forwarded only once the side has been seen high.
    logic scl_to_line_reg, sda_to_line_reg;
    logic scl_to_card_reg, sda_to_card_reg;
    logic scl_card_wait_reg, sda_card_wait_reg;
    logic scl_line_wait_reg, sda_line_wait_reg;
    logic link_on;
    assign link_on = (state_reg == ST_CONNECT);

    always_ff @(posedge clk) begin
        if (!reset_n || !link_on) begin
            scl_to_line_reg   <= 1'b0;
            scl_to_card_reg   <= 1'b0;
            scl_card_wait_reg <= 1'b0;
            scl_line_wait_reg <= 1'b0;
        end else begin
            // Drive or receive, never both; chosen by who pulled low.
            if (!scl_to_card_reg && !scl_card_wait_reg) scl_to_line_reg <= ~scl_s;
            if (!scl_to_line_reg && !scl_line_wait_reg) scl_to_card_reg <= ~line_clk_hi;
            if (scl_to_card_reg && line_clk_hi) begin
                scl_card_wait_reg <= 1'b1;
            end else if (scl_s) begin
                scl_card_wait_reg <= 1'b0;
            end
            if (scl_to_line_reg && scl_s) begin
                scl_line_wait_reg <= 1'b1;
            end else if (line_clk_hi) begin
                scl_line_wait_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || !link_on) begin
            sda_to_line_reg   <= 1'b0;
            sda_to_card_reg   <= 1'b0;
            sda_card_wait_reg <= 1'b0;
            sda_line_wait_reg <= 1'b0;
        end else begin
            if (!sda_to_card_reg && !sda_card_wait_reg) sda_to_line_reg <= ~sda_s;
            if (!sda_to_line_reg && !sda_line_wait_reg) sda_to_card_reg <= ~line_dat_hi;
            if (sda_to_card_reg && line_dat_hi) begin
                sda_card_wait_reg <= 1'b1;
            end else if (sda_s) begin
                sda_card_wait_reg <= 1'b0;
            end
            if (sda_to_line_reg && sda_s) begin
                sda_line_wait_reg <= 1'b1;
            end else if (line_dat_hi) begin
                sda_line_wait_reg <= 1'b0;
            end
        end
    end

    // Pins are released everywhere outside the connected state.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            card_scl        <= '{o: 1'b0, oe_n: 1'b1};
            card_sda        <= '{o: 1'b0, oe_n: 1'b1};
            clk_diff_plus   <= '{o: 1'b0, oe_n: 1'b1};
            clk_diff_minus  <= '{o: 1'b1, oe_n: 1'b1};
            data_diff_plus  <= '{o: 1'b0, oe_n: 1'b1};
            data_diff_minus <= '{o: 1'b1, oe_n: 1'b1};
            connected       <= 1'b0;
            sensing_on      <= 1'b0;
        end else begin
            card_scl.oe_n        <= ~(link_on & scl_to_card_reg & ~scl_to_line_reg);
            card_sda.oe_n        <= ~(link_on & sda_to_card_reg & ~sda_to_line_reg);
            // Reversed polarity: plus pulled low, minus pulled high.
            clk_diff_plus.oe_n   <= ~(link_on & scl_to_line_reg & ~scl_to_card_reg);
            clk_diff_minus.oe_n  <= ~(link_on & scl_to_line_reg & ~scl_to_card_reg);
            data_diff_plus.oe_n  <= ~(link_on & sda_to_line_reg & ~sda_to_card_reg);
            data_diff_minus.oe_n <= ~(link_on & sda_to_line_reg & ~sda_to_card_reg);
            connected            <= (state_next == ST_CONNECT);
            sensing_on           <= (state_next != ST_POWER_UP) && (state_next != ST_REF_WAIT);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_iso_when_off;
        @(posedge clk) disable iff (!reset_n)
        !en_s |=> ##1 (card_scl.oe_n && card_sda.oe_n && clk_diff_plus.oe_n
                       && data_diff_plus.oe_n);
    endproperty
    a_iso_when_off: assert property (p_iso_when_off)
        else $error("Pins driven while enable is low.");

    property p_connect_cause;
        @(posedge clk) disable iff (!reset_n)
        $rose(connected) |-> $past(en_s) && $past(state_reg == ST_ARMED);
    endproperty
    a_connect_cause: assert property (p_connect_cause)
        else $error("Connection without armed enable.");

    property p_pwr_release;
        @(posedge clk) disable iff (!reset_n)
        !pwr_s |=> state_reg == ST_POWER_UP ##1 !connected;
    endproperty
    a_pwr_release: assert property (p_pwr_release)
        else $error("Power loss did not restart.");

    property p_ref_time;
        @(posedge clk) disable iff (!reset_n)
        (state_reg == ST_REF_WAIT && timer_reg == '0 && pwr_s) |->
            (state_reg == ST_REF_WAIT) [*8];
    endproperty
    a_ref_time: assert property (p_ref_time)
        else $error("Reference wait ended too soon.");

    property p_term_gate;
        @(posedge clk) disable iff (!reset_n)
        (state_reg == ST_SENSE && !term_s) |=> state_reg != ST_TERM_WAIT;
    endproperty
    a_term_gate: assert property (p_term_gate)
        else $error("Termination timer without valid lines.");

    property p_arm_after_term;
        @(posedge clk) disable iff (!reset_n)
        $rose(state_reg == ST_ARMED) |-> $past(state_reg == ST_TERM_WAIT) && $past(timer_done);
    endproperty
    a_arm_after_term: assert property (p_arm_after_term)
        else $error("Armed before second timer.");

    property p_rerun;
        @(posedge clk) disable iff (!reset_n)
        (connected && !term_s && pwr_s) |=> ##1 (state_reg == ST_REF_WAIT || !pwr_s);
    endproperty
    a_rerun: assert property (p_rerun)
        else $error("Disconnect did not restart sequence.");

    property p_one_dir;
        @(posedge clk) disable iff (!reset_n)
        !(!card_sda.oe_n && !data_diff_plus.oe_n);
    endproperty
    a_one_dir: assert property (p_one_dir)
        else $error("Data channel drives both sides.");

    property p_reverse_pulls;
        @(posedge clk) disable iff (!reset_n)
        (link_on && !line_dat_hi && !sda_to_line_reg && !sda_line_wait_reg
         && state_next == ST_CONNECT)
            |=> ##1 (!card_sda.oe_n || !connected);
    endproperty
    a_reverse_pulls: assert property (p_reverse_pulls)
        else $error("Reversed pair not reproduced on card.");

    c_connect:    cover property (@(posedge clk) disable iff (!reset_n) $rose(connected));
    c_stop:       cover property (@(posedge clk) disable iff (!reset_n)
                                  state_reg == ST_ARMED && stop_evt);
    c_card_drive: cover property (@(posedge clk) disable iff (!reset_n) !card_sda.oe_n);
    c_line_drive: cover property (@(posedge clk) disable iff (!reset_n) !clk_diff_plus.oe_n);
endmodule

// >>> testbench/diff_line_model.sv
// Behavioural model of the terminated differential pairs and one peer node on them.
`timescale 1ns/10ps
module diff_line_model
    import hotswap_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     terminated,
    input  wire logic                     peer_clk_low,
    input  wire logic                     peer_data_low,
    input  wire hotswap_pkg::od_pin_t     clk_diff_plus,
    input  wire hotswap_pkg::od_pin_t     clk_diff_minus,
    input  wire hotswap_pkg::od_pin_t     data_diff_plus,
    input  wire hotswap_pkg::od_pin_t     data_diff_minus,
    output hotswap_pkg::line_sense_t      sense
);
    // ****************************************************************
    // Line levels
    // ****************************************************************
    // An open pair has no bias, so its difference wanders; a toggling pattern stands in.
    logic float_q = 1'b0;
    logic clk_rev;
    logic data_rev;

    always @(posedge clk) begin
        float_q <= ~float_q;
    end

    assign clk_rev  = (clk_diff_plus.oe_n == 1'b0 && clk_diff_plus.o == 1'b0)
                   || (clk_diff_minus.oe_n == 1'b0 && clk_diff_minus.o == 1'b1)
                   || peer_clk_low;
    assign data_rev = (data_diff_plus.oe_n == 1'b0 && data_diff_plus.o == 1'b0)
                   || (data_diff_minus.oe_n == 1'b0 && data_diff_minus.o == 1'b1)
                   || peer_data_low;

    assign sense.clk_plus_gt_minus   = terminated ? ~clk_rev : float_q;
    assign sense.data_plus_gt_minus  = terminated ? ~data_rev : float_q;
    assign sense.clk_minus_below_hi  = terminated;
    assign sense.data_minus_below_hi = terminated;
    assign sense.clk_plus_above_lo   = terminated;
    assign sense.data_plus_above_lo  = terminated;
endmodule

// >>> testbench/diff_bus_hotswap_connect_tb.sv
// Self-checking testbench for the differential bus hot-swap connect logic.
`timescale 1ns/10ps
module diff_bus_hotswap_connect_tb;
    import hotswap_pkg::*;

    localparam int REF_N  = 20;
    localparam int TERM_N = 40;
    localparam int IDLE_N = 200;

    logic        clk;
    logic        reset_n;
    logic        supplies_ok;
    logic        connect_en;
    logic        terminated;
    logic        peer_clk_low;
    logic        peer_data_low;
    logic        master_scl_low;
    logic        card_scl_in;
    logic        card_sda_in;
    line_sense_t sense;
    od_pin_t     card_scl;
    od_pin_t     card_sda;
    od_pin_t     clk_diff_plus;
    od_pin_t     clk_diff_minus;
    od_pin_t     data_diff_plus;
    od_pin_t     data_diff_minus;
    logic        connected;
    logic        sensing_on;
    int          n_errors;
    int          cmp_count;
    int          n;

    // Card side wires are pulled up; any party driving low wins.
    assign card_scl_in = ~((card_scl.oe_n == 1'b0 && card_scl.o == 1'b0) || master_scl_low);
    assign card_sda_in = ~(card_sda.oe_n == 1'b0 && card_sda.o == 1'b0);

    diff_bus_hotswap_connect #(.REF_CNT(REF_N), .TERM_CNT(TERM_N), .IDLE_CNT(IDLE_N)) DUT (
        .clk(clk), .reset_n(reset_n), .supplies_ok(supplies_ok), .connect_en(connect_en),
        .sense(sense), .card_scl_in(card_scl_in), .card_sda_in(card_sda_in),
        .card_scl(card_scl), .card_sda(card_sda), .clk_diff_plus(clk_diff_plus),
        .clk_diff_minus(clk_diff_minus), .data_diff_plus(data_diff_plus),
        .data_diff_minus(data_diff_minus), .connected(connected), .sensing_on(sensing_on));

    diff_line_model line (
        .clk(clk), .terminated(terminated), .peer_clk_low(peer_clk_low),
        .peer_data_low(peer_data_low), .clk_diff_plus(clk_diff_plus),
        .clk_diff_minus(clk_diff_minus), .data_diff_plus(data_diff_plus),
        .data_diff_minus(data_diff_minus), .sense(sense));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] oe_all();
        return {2'b00, card_scl.oe_n, card_sda.oe_n, clk_diff_plus.oe_n, clk_diff_minus.oe_n,
                data_diff_plus.oe_n, data_diff_minus.oe_n};
    endfunction

    task automatic wait_conn(input logic val, input int lim, output int cnt);
        cnt = 0;
        while (connected !== val && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_power_up();
        check(oe_all(), 8'h3F);
        @(negedge clk);
        supplies_ok = 1'b1;
        n = 0;
        while (sensing_on !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check(8'(n >= REF_N && n <= REF_N + 8), 8'h01);
        check(oe_all(), 8'h3F);
        wait_conn(1'b1, TERM_N + IDLE_N + 30, n);
        check(8'(connected), 8'h01);
        check(8'(n >= TERM_N), 8'h01);
        $display("test power_up done");
    endtask

    task automatic test_card_to_line();
        master_scl_low = 1'b1;
        repeat (8) @(negedge clk);
        check({clk_diff_plus.oe_n, clk_diff_minus.oe_n, clk_diff_plus.o, clk_diff_minus.o,
               card_scl.oe_n, 3'b000}, 8'h18);
        master_scl_low = 1'b0;
        repeat (8) @(negedge clk);
        check(oe_all(), 8'h3F);
        $display("test card_to_line done");
    endtask

    task automatic test_line_to_card();
        peer_data_low = 1'b1;
        repeat (8) @(negedge clk);
        check({card_sda.oe_n, card_sda.o, data_diff_plus.oe_n, data_diff_minus.oe_n,
               4'h0}, 8'h30);
        peer_data_low = 1'b0;
        repeat (8) @(negedge clk);
        check(oe_all(), 8'h3F);
        $display("test line_to_card done");
    endtask

    task automatic test_enable_and_stop();
        connect_en = 1'b0;
        wait_conn(1'b0, 16, n);
        repeat (REF_N + TERM_N + 40) @(negedge clk);
        check(8'(connected), 8'h00);
        check(oe_all(), 8'h3F);
        // A transfer is already open on the pairs, so only a STOP may let it in.
        peer_data_low = 1'b1;
        repeat (10) @(negedge clk);
        connect_en = 1'b1;
        repeat (20) @(negedge clk);
        check(8'(connected), 8'h00);
        peer_data_low = 1'b0;
        wait_conn(1'b1, 16, n);
        check(8'(connected), 8'h01);
        $display("test enable_and_stop done");
    endtask

    task automatic test_term_loss();
        terminated = 1'b0;
        wait_conn(1'b0, 16, n);
        check(8'(n < 16), 8'h01);
        check(oe_all(), 8'h3F);
        repeat (10) @(negedge clk);
        terminated = 1'b1;
        wait_conn(1'b1, REF_N + TERM_N + IDLE_N + 40, n);
        check(8'(connected), 8'h01);
        check(8'(n >= TERM_N), 8'h01);
        $display("test term_loss done");
    endtask

    task automatic test_supply_loss();
        supplies_ok = 1'b0;
        wait_conn(1'b0, 16, n);
        repeat (4) @(negedge clk);
        check({6'h00, sensing_on, connected}, 8'h00);
        check(oe_all(), 8'h3F);
        supplies_ok = 1'b1;
        wait_conn(1'b1, REF_N + TERM_N + IDLE_N + 40, n);
        check(8'(connected), 8'h01);
        check(8'(n >= REF_N + TERM_N), 8'h01);
        $display("test supply_loss done");
    endtask

    // ****************************************************************
    // Clock, reset, sequence and watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        n_errors = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        supplies_ok = 1'b0;
        connect_en = 1'b1;
        terminated = 1'b1;
        peer_clk_low = 1'b0;
        peer_data_low = 1'b0;
        master_scl_low = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        test_power_up();
        test_card_to_line();
        test_line_to_card();
        test_enable_and_stop();
        test_term_loss();
        test_supply_loss();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule
